// ### verilog/btl_trigger.sv
`timescale 1ns/1ps
// Functional notes
// - First comparator matches against value one
// - Second comparator matches value two under mask
// - Program space compares fetch-bus address, qualified
// - Data space compares data-bus address, qualified
// - Second comparator may compare data value
// - Access any/read/write; fetch only program space
// - OR mode fires on either sub-trigger
// - AND mode fires when both match together
// - Sequence arms on designated sub-trigger, fires on other
// - Counted sub-trigger matches after N occurrences
// - Counted combination must occur N times
// - Split trace mode: designated sub-trigger starts trace
// - Split trace mode: other sub-trigger halts trace
// - Non-split counter mode emits counter stop events
// - Split counter mode: designated sub-trigger starts counter
// - Split counter mode: other sub-trigger halts counter
// - Value compare matches selected transfer width only
// - Core locked out cannot reach registers
module btl_trigger
#(
  parameter int COUNT_W = 16
)
(
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic [btl_pkg::REG_AW-1:0]      reg_addr,
  input  wire logic [btl_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [btl_pkg::DATA_W-1:0]      reg_rdata,
  input  wire logic                            core_locked_out,
  input  wire btl_pkg::btl_pbus_type           pbus,
  input  wire btl_pkg::btl_xbus_type           xbus,
  output btl_pkg::btl_evt_type                 evt,
  output logic                                 trace_active,
  output logic                                 counter_running
);
  import btl_pkg::*;

  // ==========================================================
  // Register storage
  // Control fields
  logic                ctrl_en_reg;
  btl_comb_type        ctrl_mode_reg;
  logic                ctrl_order_reg;
  btl_cnt_type         ctrl_cnt_reg;
  logic                ctrl_cntr_reg;
  btl_width_type       ctrl_width_reg;

  // First comparator setup
  logic [DATA_W-1:0]   value1_reg;
  btl_space_type       space1_reg;
  btl_acc_type         acc1_reg;

  // Second comparator setup
  logic [DATA_W-1:0]   value2_reg;
  logic [DATA_W-1:0]   mask_reg;
  btl_space_type       space2_reg;
  btl_acc_type         acc2_reg;

  // Counting, sequencing and stop state
  logic [COUNT_W-1:0]  count_load_reg;
  logic [COUNT_W-1:0]  count_reg;
  btl_seq_type         seq_reg;
  logic                stopped_reg;

  // Qualified strobes
  logic                wr_ok;
  logic                rd_ok;
  logic                reload;

  // Locked-out core gets neither writes nor reads
  assign wr_ok = reg_wr & ~core_locked_out;
  assign rd_ok = reg_rd & ~core_locked_out;

  // Reprogramming restarts counting and sequencing
  assign reload = wr_ok & ((reg_addr == CTRL_OFS) | (reg_addr == COUNT_OFS));

  // ==========================================================
  // Register writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_en_reg    <= 1'b0;
      ctrl_mode_reg  <= COMB_OR;
      ctrl_order_reg <= 1'b0;
      ctrl_cnt_reg   <= CNT_NONE;
      ctrl_cntr_reg  <= 1'b0;
      ctrl_width_reg <= WID_NONE;
      value1_reg     <= '0;
      space1_reg     <= SPACE_PROG;
      acc1_reg       <= ACC_ANY;
      value2_reg     <= '0;
      mask_reg       <= MASK_RST;
      space2_reg     <= SPACE_PROG;
      acc2_reg       <= ACC_ANY;
      count_load_reg <= '0;
    end
    else if (wr_ok)
    begin
      if (reg_addr == CTRL_OFS)
      begin
        ctrl_en_reg    <= reg_wdata[CTRL_EN_BIT];
        ctrl_mode_reg  <= btl_comb_type'(reg_wdata[CTRL_MODE_LSB +: 2]);
        ctrl_order_reg <= reg_wdata[CTRL_ORDER_BIT];
        ctrl_cnt_reg   <= btl_cnt_type'(reg_wdata[CTRL_CNT_LSB +: 2]);
        ctrl_cntr_reg  <= reg_wdata[CTRL_CNTR_BIT];
        ctrl_width_reg <= btl_width_type'(reg_wdata[CTRL_WIDTH_LSB +: 2]);
      end
      else if (reg_addr == VALUE1_OFS)
        value1_reg <= reg_wdata;
      else if (reg_addr == CFG1_OFS)
      begin
        space1_reg <= btl_space_type'(reg_wdata[CFG_SPACE_LSB +: 2]);
        acc1_reg   <= btl_acc_type'(reg_wdata[CFG_ACC_LSB +: 2]);
      end
      else if (reg_addr == VALUE2_OFS)
        value2_reg <= reg_wdata;
      else if (reg_addr == MASK_OFS)
        mask_reg <= reg_wdata;
      else if (reg_addr == CFG2_OFS)
      begin
        space2_reg <= btl_space_type'(reg_wdata[CFG_SPACE_LSB +: 2]);
        acc2_reg   <= btl_acc_type'(reg_wdata[CFG_ACC_LSB +: 2]);
      end
      else if (reg_addr == COUNT_OFS)
        count_load_reg <= reg_wdata[COUNT_W-1:0];  // Holds N minus one
    end
  end

  // ==========================================================
  // Comparators
  // Access kind filter
  function automatic logic acc_ok(input btl_acc_type acc, input logic wr,
                                  input logic fe, input logic is_prog);
    logic ok;
    ok = 1'b0;
    case (acc)
      ACC_ANY:   ok = 1'b1;
      ACC_READ:  ok = ~wr & ~fe;
      ACC_WRITE: ok = wr;
      ACC_FETCH: ok = fe & is_prog;  // Fetch only in program space
      default:   ok = 1'b0;
    endcase
    return ok;
  endfunction

  // One comparator against both buses
  function automatic logic cmp_hit(input btl_space_type sp, input btl_acc_type acc,
                                   input logic [DATA_W-1:0] val,
                                   input logic [DATA_W-1:0] msk,
                                   input logic value_ok,
                                   input btl_pbus_type pb, input btl_xbus_type xb,
                                   input btl_width_type wsel);
    logic               hit;
    logic [DATA_W-1:0]  pa;
    logic [DATA_W-1:0]  xa;
    hit = 1'b0;
    pa  = {{(DATA_W-ADDR_W){1'b0}}, pb.addr};
    xa  = {{(DATA_W-ADDR_W){1'b0}}, xb.addr};
    case (sp)
      // Program address with access kind
      SPACE_PROG:
        hit = pb.valid & (((pa ^ val) & msk) == '0)
              & acc_ok(acc, pb.write, pb.fetch, 1'b1);
      // Data address with access kind
      SPACE_DATA:
        hit = xb.valid & (((xa ^ val) & msk) == '0)
              & acc_ok(acc, xb.write, 1'b0, 1'b0);
      // Data value of selected width
      SPACE_VALUE:
        hit = value_ok & xb.valid & (wsel != WID_NONE) & (xb.width == wsel)
              & (((xb.data ^ val) & msk) == '0)
              & acc_ok(acc, xb.write, 1'b0, 1'b0);
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Raw comparator hits
  logic raw1;
  logic raw2;

  // First comparator: full-width compare, no value mode
  assign raw1 = ctrl_en_reg & cmp_hit(space1_reg, acc1_reg, value1_reg, MASK_RST,
                                      1'b0, pbus, xbus, ctrl_width_reg);
  // Second comparator: masked, value mode allowed
  assign raw2 = ctrl_en_reg & cmp_hit(space2_reg, acc2_reg, value2_reg, mask_reg,
                                      1'b1, pbus, xbus, ctrl_width_reg);

  // ==========================================================
  // Occurrence counting on a single sub-trigger
  // Counting qualifiers
  logic cnt_zero;
  logic sub1;
  logic sub2;

  assign cnt_zero = (count_reg == '0);
  assign sub1 = (ctrl_cnt_reg == CNT_SUB1) ? (raw1 & cnt_zero) : raw1;
  assign sub2 = (ctrl_cnt_reg == CNT_SUB2) ? (raw2 & cnt_zero) : raw2;

  // ==========================================================
  // Combination
  // Ordering and combined results
  logic lead;
  logic follow;
  logic comb;
  logic fire;
  logic split;
  logic cnt_event;

  assign lead   = ctrl_order_reg ? sub2 : sub1;
  assign follow = ctrl_order_reg ? sub1 : sub2;
  assign split  = (ctrl_mode_reg == COMB_SPLIT);

  // Combined condition for this edge
  always_comb
  begin
    comb = 1'b0;
    case (ctrl_mode_reg)
      COMB_OR:    comb = sub1 | sub2;
      COMB_AND:   comb = sub1 & sub2;
      COMB_SEQ:   comb = (seq_reg == SEQ_ARMED) & follow;
      default:    comb = 1'b0;
    endcase
  end

  // Combination counted N times when selected
  assign fire = (ctrl_cnt_reg == CNT_COMB) ? (comb & cnt_zero) : comb;

  // Event that consumes one occurrence
  always_comb
  begin
    cnt_event = 1'b0;
    case (ctrl_cnt_reg)
      CNT_SUB1: cnt_event = raw1;
      CNT_SUB2: cnt_event = raw2;
      CNT_COMB: cnt_event = comb;
      default:  cnt_event = 1'b0;
    endcase
  end

  // ==========================================================
  // Occurrence counter: decrement, reload on the Nth
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_reg <= '0;
    else if (reload)
      count_reg <= (reg_addr == COUNT_OFS) ? reg_wdata[COUNT_W-1:0] : count_load_reg;
    else if (cnt_event)
      count_reg <= cnt_zero ? count_load_reg : count_reg - 1'b1;
  end

  // ==========================================================
  // Sequence state: arm on leading, fire on following
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      seq_reg <= SEQ_IDLE;
    else if (reload || ctrl_mode_reg != COMB_SEQ)
      seq_reg <= SEQ_IDLE;
    else
    begin
      case (seq_reg)
        SEQ_IDLE:
          if (lead)
            seq_reg <= SEQ_ARMED;
        SEQ_ARMED:
          if (fire)
            seq_reg <= SEQ_IDLE;
        default:
          seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Event outputs, registered pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      evt <= '0;
    else
    begin
      evt.trigger       <= ~ctrl_cntr_reg & ~split & fire;
      evt.trace_start   <= ~ctrl_cntr_reg & split & lead;
      evt.trace_halt    <= ~ctrl_cntr_reg & split & follow;
      evt.counter_stop  <= ctrl_cntr_reg & ~split & fire;
      evt.counter_start <= ctrl_cntr_reg & split & lead;
      evt.counter_halt  <= ctrl_cntr_reg & split & follow;
    end
  end

  // ==========================================================
  // Trace capture level; halt wins a same-edge tie
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      trace_active <= 1'b0;
    else if (~ctrl_cntr_reg & split & follow)
      trace_active <= 1'b0;
    else if (~ctrl_cntr_reg & split & lead)
      trace_active <= 1'b1;
  end

  // Special counter run level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      counter_running <= 1'b0;
    else if (ctrl_cntr_reg & (split ? follow : fire))
      counter_running <= 1'b0;
    else if (ctrl_cntr_reg & split & lead)
      counter_running <= 1'b1;
  end

  // ==========================================================
  // Sticky stop flag: set wins over write-one clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      stopped_reg <= 1'b0;
    else if (ctrl_cntr_reg & ~split & fire)
      stopped_reg <= 1'b1;
    else if (wr_ok && reg_addr == STATUS_OFS && reg_wdata[STAT_STOP_BIT])
      stopped_reg <= 1'b0;
  end

  // ==========================================================
  // Status word as software sees it
  logic [DATA_W-1:0] status_word;

  always_comb
  begin
    status_word                          = '0;
    status_word[STAT_ARMED_BIT]          = (seq_reg == SEQ_ARMED);
    status_word[STAT_TRACE_BIT]          = trace_active;
    status_word[STAT_CRUN_BIT]           = counter_running;
    status_word[STAT_STOP_BIT]           = stopped_reg;
    status_word[STAT_CNT_LSB +: COUNT_W] = count_reg;
  end

  // ==========================================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (!rd_ok)
      reg_rdata <= '0;
    else if (reg_addr == CTRL_OFS)
      reg_rdata <= DATA_W'({ctrl_width_reg, ctrl_cntr_reg, ctrl_cnt_reg,
                            ctrl_order_reg, ctrl_mode_reg, ctrl_en_reg});
    else if (reg_addr == VALUE1_OFS)
      reg_rdata <= value1_reg;
    else if (reg_addr == CFG1_OFS)
      reg_rdata <= DATA_W'({acc1_reg, space1_reg});
    else if (reg_addr == VALUE2_OFS)
      reg_rdata <= value2_reg;
    else if (reg_addr == MASK_OFS)
      reg_rdata <= mask_reg;
    else if (reg_addr == CFG2_OFS)
      reg_rdata <= DATA_W'({acc2_reg, space2_reg});
    else if (reg_addr == COUNT_OFS)
      reg_rdata <= DATA_W'(count_load_reg);
    else if (reg_addr == STATUS_OFS)
      reg_rdata <= status_word;
    else
      reg_rdata <= '0;
  end

endmodule

// ### include/btl_pkg.sv
package btl_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int REG_AW = 6;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [REG_AW-1:0] CTRL_OFS   = 6'h00;
  localparam logic [REG_AW-1:0] VALUE1_OFS = 6'h04;
  localparam logic [REG_AW-1:0] CFG1_OFS   = 6'h08;
  localparam logic [REG_AW-1:0] VALUE2_OFS = 6'h0C;
  localparam logic [REG_AW-1:0] MASK_OFS   = 6'h10;
  localparam logic [REG_AW-1:0] CFG2_OFS   = 6'h14;
  localparam logic [REG_AW-1:0] COUNT_OFS  = 6'h18;
  localparam logic [REG_AW-1:0] STATUS_OFS = 6'h1C;

  // ==========================================================
  // Control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_MODE_LSB   = 1;   // 2 bits
  localparam int CTRL_ORDER_BIT  = 3;   // 1: second comparator leads
  localparam int CTRL_CNT_LSB    = 4;   // 2 bits
  localparam int CTRL_CNTR_BIT   = 6;   // 1: counter action, 0: normal
  localparam int CTRL_WIDTH_LSB  = 7;   // 2 bits

  // Comparator config fields
  localparam int CFG_SPACE_LSB   = 0;   // 2 bits
  localparam int CFG_ACC_LSB     = 2;   // 2 bits

  // Status fields
  localparam int STAT_ARMED_BIT  = 0;
  localparam int STAT_TRACE_BIT  = 1;
  localparam int STAT_CRUN_BIT   = 2;
  localparam int STAT_STOP_BIT   = 3;
  localparam int STAT_CNT_LSB    = 16;

  // Reset value of mask: compare every bit
  localparam logic [DATA_W-1:0] MASK_RST = 32'hFFFFFFFF;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    COMB_OR    = 2'h0,
    COMB_AND   = 2'h1,
    COMB_SEQ   = 2'h2,
    COMB_SPLIT = 2'h3
  } btl_comb_type;

  typedef enum logic [1:0] {
    SPACE_PROG  = 2'h0,
    SPACE_DATA  = 2'h1,
    SPACE_VALUE = 2'h2
  } btl_space_type;

  typedef enum logic [1:0] {
    ACC_ANY   = 2'h0,
    ACC_READ  = 2'h1,
    ACC_WRITE = 2'h2,
    ACC_FETCH = 2'h3
  } btl_acc_type;

  typedef enum logic [1:0] {
    CNT_NONE  = 2'h0,
    CNT_SUB1  = 2'h1,
    CNT_SUB2  = 2'h2,
    CNT_COMB  = 2'h3
  } btl_cnt_type;

  typedef enum logic [1:0] {
    WID_NONE = 2'h0,
    WID_BYTE = 2'h1,
    WID_WORD = 2'h2,
    WID_LONG = 2'h3
  } btl_width_type;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h1,
    SEQ_ARMED = 2'h2
  } btl_seq_type;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic              valid;
    logic              fetch;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } btl_pbus_type;

  typedef struct packed {
    logic              valid;
    logic              write;
    btl_width_type     width;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } btl_xbus_type;

  typedef struct packed {
    logic trigger;
    logic trace_start;
    logic trace_halt;
    logic counter_start;
    logic counter_halt;
    logic counter_stop;
  } btl_evt_type;

endpackage

// ### test/btl_core_model.sv
`timescale 1ns/1ps
// ============================================================
// Core bus model: one completing access per call
module btl_core_model
(
  input  wire logic          clk,
  output btl_pkg::btl_pbus_type pbus,
  output btl_pkg::btl_xbus_type xbus
);
  import btl_pkg::*;

  // Buses idle at time zero
  initial
  begin
    pbus = '0;
    xbus = '0;
  end

  // Drive both buses one cycle, then release with inverted fields
  task automatic acc(input btl_pbus_type p, input btl_xbus_type x);
    btl_pbus_type rp;
    btl_xbus_type rx;
    @(posedge clk);
    pbus <= p;
    xbus <= x;
    rp = ~p;
    rx = ~x;
    rp.valid = 1'b0;
    rx.valid = 1'b0;
    @(posedge clk);
    pbus <= rp; // Stale fields never look like the last access
    xbus <= rx;
  endtask
endmodule

// ### test/btl_trigger_assertions.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checker
module btl_trigger_chk
#(
  parameter int COUNT_W = 16
)
(
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [btl_pkg::REG_AW-1:0] reg_addr,
  input wire logic [btl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [btl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       core_locked_out,
  input wire btl_pkg::btl_pbus_type      pbus,
  input wire btl_pkg::btl_xbus_type      xbus,
  input wire btl_pkg::btl_evt_type       evt,
  input wire logic                       trace_active,
  input wire logic                       counter_running
);
  import btl_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_lock_rd; $past(reg_rd && core_locked_out) |-> reg_rdata == '0; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("locked read gave data");
  property p_trig_src; evt.trigger |-> $past(pbus.valid || xbus.valid); endproperty
  a_trig_src: assert property (p_trig_src) else $error("trigger without access");
  property p_stop_src;
    evt.counter_stop |-> $past(pbus.valid || xbus.valid) && !evt.trigger;
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("bad counter stop");
  property p_ts; evt.trace_start && !evt.trace_halt |-> trace_active; endproperty
  a_ts: assert property (p_ts) else $error("trace not started");
  property p_th; evt.trace_halt |-> !trace_active; endproperty
  a_th: assert property (p_th) else $error("trace not halted");
  property p_ta_rise; $rose(trace_active) |-> evt.trace_start; endproperty
  a_ta_rise: assert property (p_ta_rise) else $error("trace rose alone");
  property p_cs; evt.counter_start && !evt.counter_halt |-> counter_running; endproperty
  a_cs: assert property (p_cs) else $error("counter not started");
  property p_ch; evt.counter_halt || evt.counter_stop |-> !counter_running; endproperty
  a_ch: assert property (p_ch) else $error("counter not halted");
  property p_cr_rise; $rose(counter_running) |-> evt.counter_start; endproperty
  a_cr_rise: assert property (p_cr_rise) else $error("counter rose alone");

  c_trig: cover property (evt.trigger);
  c_trace: cover property (evt.trace_start);
  c_stop: cover property (evt.counter_stop);
endmodule

bind btl_trigger btl_trigger_chk #(.COUNT_W(COUNT_W)) i_chk
(
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_locked_out(core_locked_out),
  .pbus(pbus), .xbus(xbus), .evt(evt), .trace_active(trace_active),
  .counter_running(counter_running)
);

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import btl_pkg::*;

  logic                clk;
  logic                rst_n;
  logic                reg_wr;
  logic                reg_rd;
  logic                core_locked_out;
  logic [REG_AW-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic [DATA_W-1:0]   reg_rdata;
  btl_pbus_type        pbus;
  btl_xbus_type        xbus;
  btl_evt_type         evt;
  logic                trace_active;
  logic                counter_running;
  int                  miscompares;
  int                  samples_checked;

  localparam logic [23:0] AA = 24'h001234;
  localparam logic [23:0] BB = 24'h00ABCD;
  localparam btl_pbus_type NP = '0;
  localparam btl_xbus_type NX = '0;
  // Expected {evt, trace_active, counter_running}
  localparam logic [7:0] TRG = 8'h80;
  localparam logic [7:0] TS = 8'h40;
  localparam logic [7:0] TH = 8'h20;
  localparam logic [7:0] CS = 8'h10;
  localparam logic [7:0] CH = 8'h08;
  localparam logic [7:0] STP = 8'h04;
  localparam logic [7:0] TA = 8'h02;
  localparam logic [7:0] CR = 8'h01;

  // ============================================================
  // Clock, design and core model
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  btl_trigger #(.COUNT_W(16)) i_dut
  (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_locked_out(core_locked_out),
    .pbus(pbus), .xbus(xbus), .evt(evt), .trace_active(trace_active),
    .counter_running(counter_running)
  );

  btl_core_model i_core (.clk(clk), .pbus(pbus), .xbus(xbus));

  // ============================================================
  // Helpers
  function automatic logic [31:0] ctl(logic [1:0] m, logic o, logic [1:0] c, logic k,
                                      logic [1:0] w);
    return {23'h0, w, k, c, o, m, 1'b1};
  endfunction

  function automatic logic [31:0] cfg(logic [1:0] s, logic [1:0] a);
    return {28'h0, a, s};
  endfunction

  function automatic btl_pbus_type P(logic f, logic w, logic [23:0] a);
    return '{1'b1, f, w, a};
  endfunction

  function automatic btl_xbus_type X(logic w, logic [1:0] wd, logic [23:0] a, logic [31:0] d);
    return '{1'b1, w, btl_width_type'(wd), a, d};
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp("reg_rdata", e, reg_rdata);
  endtask

  task automatic go(input btl_pbus_type p, input btl_xbus_type x, input logic [7:0] e,
                    input string nm);
    i_core.acc(p, x);
    @(negedge clk);
    cmp(nm, {24'h0, e}, {24'h0, evt, trace_active, counter_running});
  endtask

  // ============================================================
  // Scenarios
  task automatic t_regs;
    rd(MASK_OFS, 32'hFFFFFFFF);
    rd(CTRL_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0);
    wr(6'h20, 32'h5);
    rd(6'h20, 32'h0);
    @(posedge clk) core_locked_out <= 1'b1;
    wr(VALUE1_OFS, 32'h77);
    rd(VALUE1_OFS, 32'h0);
    @(posedge clk) core_locked_out <= 1'b0;
    rd(VALUE1_OFS, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_or;
    wr(VALUE1_OFS, {8'h0, AA});
    wr(CFG1_OFS, cfg(SPACE_PROG, ACC_ANY));
    wr(VALUE2_OFS, {8'h0, BB});
    wr(CFG2_OFS, cfg(SPACE_PROG, ACC_FETCH));
    wr(CTRL_OFS, ctl(COMB_OR, 0, CNT_NONE, 0, WID_NONE));
    go(P(0, 0, AA), NX, TRG, "or first");
    go(P(1, 0, BB), NX, TRG, "or second fetch");
    go(P(0, 1, BB), NX, 8'h0, "or second write");
    go(NP, X(0, WID_WORD, AA, 0), 8'h0, "or data bus");
    for (int k = 0; k < 4; k++)
    begin
      wr(CFG1_OFS, cfg(SPACE_DATA, k[1:0]));
      go(NP, X(0, WID_WORD, AA, 0), (k < 2) ? TRG : 8'h0, "acc read");
      go(NP, X(1, WID_WORD, AA, 0), (k % 3 == 0 || k == 2) && k != 3 ? TRG : 8'h0,
         "acc write");
    end
    $display("t_or done");
  endtask

  task automatic t_and;
    wr(CFG1_OFS, cfg(SPACE_DATA, ACC_WRITE));
    wr(VALUE2_OFS, 32'h1234);
    wr(MASK_OFS, 32'h0000FFFF);
    wr(CFG2_OFS, cfg(SPACE_VALUE, ACC_ANY));
    for (int j = 1; j < 4; j++)
    begin
      wr(CTRL_OFS, ctl(COMB_AND, 0, CNT_NONE, 0, j[1:0]));
      go(NP, X(1, j[1:0], AA, 32'hABCD1234), TRG, "and hit");
      go(NP, X(1, 2'(j % 3 + 1), AA, 32'hABCD1234), 8'h0, "and width");
    end
    go(NP, X(1, WID_LONG, AA, 32'hABCD1235), 8'h0, "and value");
    go(NP, X(0, WID_LONG, AA, 32'h1234), 8'h0, "and read");
    $display("t_and done");
  endtask

  task automatic t_seq;
    wr(VALUE2_OFS, {8'h0, BB});
    wr(MASK_OFS, 32'hFFFFFFFF);
    wr(CFG1_OFS, cfg(SPACE_PROG, ACC_ANY));
    wr(CFG2_OFS, cfg(SPACE_PROG, ACC_ANY));
    for (int o = 0; o < 2; o++)
    begin
      wr(CTRL_OFS, ctl(COMB_SEQ, o[0], CNT_NONE, 0, WID_NONE));
      go(P(0, 0, o ? AA : BB), NX, 8'h0, "seq follow early");
      go(P(0, 0, o ? BB : AA), NX, 8'h0, "seq lead");
      rd(STATUS_OFS, 32'h1);
      go(P(0, 0, o ? AA : BB), NX, TRG, "seq fire");
    end
    $display("t_seq done");
  endtask

  task automatic t_count;
    wr(CTRL_OFS, ctl(COMB_OR, 0, CNT_SUB1, 0, WID_NONE));
    wr(COUNT_OFS, 32'h2);
    go(P(0, 0, AA), NX, 8'h0, "count one");
    go(P(0, 0, AA), NX, 8'h0, "count two");
    go(P(0, 0, AA), NX, TRG, "count three");
    go(P(0, 0, BB), NX, TRG, "count other");
    wr(CTRL_OFS, ctl(COMB_OR, 0, CNT_COMB, 0, WID_NONE));
    wr(COUNT_OFS, 32'h1);
    go(P(0, 0, BB), NX, 8'h0, "comb one");
    go(P(0, 0, AA), NX, TRG, "comb two");
    wr(CTRL_OFS, ctl(COMB_OR, 0, CNT_SUB2, 0, WID_NONE));
    go(P(0, 0, BB), NX, 8'h0, "sub2 one");
    go(P(0, 0, BB), NX, TRG, "sub2 two");
    $display("t_count done");
  endtask

  task automatic t_split;
    wr(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, ctl(COMB_SPLIT, 0, CNT_NONE, 0, WID_NONE));
    go(P(0, 0, AA), NX, TS | TA, "trace start");
    go(P(0, 0, BB), NX, TH, "trace halt");
    wr(CTRL_OFS, ctl(COMB_SPLIT, 0, CNT_NONE, 1, WID_NONE));
    go(P(0, 0, AA), NX, CS | CR, "counter start");
    go(P(0, 0, BB), NX, CH, "counter halt");
    go(P(0, 0, AA), NX, CS | CR, "counter restart");
    wr(CTRL_OFS, ctl(COMB_OR, 0, CNT_NONE, 1, WID_NONE));
    go(P(0, 0, AA), NX, STP, "counter stop");
    rd(STATUS_OFS, 32'h8);
    wr(STATUS_OFS, 32'h8);
    rd(STATUS_OFS, 32'h0);
    $display("t_split done");
  endtask

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    core_locked_out = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_or();
    t_and();
    t_seq();
    t_count();
    t_split();
    print_verdict();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule
